// *** tb_tcc_timer16.sv ***
// self-checking bench for the 16-bit timer core
// assumes the core, its checker and the interrupt host model
`include "tcc_consts.vh"

// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module tb_tcc_timer16;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0]  wstrb = 4'hF, irq_req, irq_ack, ack_en = 4'h0;
  logic        external_count_pin = 1'b0, capture_in_pin = 1'b0;
  logic        comparator_output = 1'b0, awready, wready, arready;
  logic        bvalid, rvalid, wave_out_a, wave_out_b;
  logic        wave_en_a, wave_en_b;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [7:0]  rv_ofs [4] = '{8'h00, 8'h04, 8'h28, 8'h2C};
  int          error_cnt = 0, check_count = 0;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  tcc_timer16 i_tcc_timer16 (.*);
  tcc_irq_host i_tcc_irq_host (.aclk, .aresetn, .irq_req, .ack_en,
    .irq_ack);

  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  // bready stands with the request until bvalid is sampled high
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input string n, input logic [7:0] a, e);
    rd(a);
    chk(n, {24'h0, e}, rd_v);
  endtask

  // high byte goes to the shared shadow first
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h04, v[15:8]);
    wr(a, v[7:0]);
  endtask

  task automatic r16(input string n, input logic [7:0] a,
                     input logic [15:0] e);
    rc(n, a, e[7:0]);
    rc(n, a + 8'h04, e[15:8]);
  endtask

  // n pulses on the count pin, then counting is stopped
  task automatic ext(input logic [2:0] cs, input int n);
    wr(8'h04, {5'h00, cs});
    repeat (n)
    begin
      @(posedge aclk) external_count_pin <= 1'b1;
      @(posedge aclk) external_count_pin <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    wr(8'h04, 8'h00);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rv_ofs[k]) rc("reset value", rv_ofs[k], 8'h00);
    wr(8'h00, 8'h31);
    rc("control first", 8'h00, 8'h31);
    chk("wave enable b", 32'h1, wave_en_b);
    rd(8'h30);
    chk("unmapped read", `TCC_RESP_SLVERR, rs);
    wr(8'h30, 8'hFF);
    chk("unmapped write", `TCC_RESP_SLVERR, bs);
    $display("registers done");
    wr(8'h00, 8'h00);
    w16(8'h08, 16'h12FE);
    repeat (20) @(posedge aclk);
    r16("count frozen", 8'h08, 16'h12FE);
    ext(`TCC_CS_EXT_RISE, 3);
    r16("rising count", 8'h08, 16'h1301);
    ext(`TCC_CS_EXT_FALL, 2);
    r16("falling count", 8'h08, 16'h1303);
    $display("clock select done");
    w16(8'h10, 16'h0005);
    w16(8'h18, 16'h0006);
    r16("compare a", 8'h10, 16'h0005);
    wr(8'h00, 8'h70);
    w16(8'h08, 16'h0003);
    ext(`TCC_CS_EXT_RISE, 4);
    rc("match flags", 8'h2C, 8'h06);
    chk("masked req", 32'h0, irq_req);
    chk("toggle a", 32'h1, wave_out_a);
    chk("set b", 32'h1, wave_out_b);
    chk("wave enable a", 32'h1, wave_en_a);
    wr(8'h28, 8'h06);
    chk("both req", 32'h6, irq_req);
    wr(8'h2C, 8'h02);
    rc("clear a", 8'h2C, 8'h04);
    chk("req b", 32'h4, irq_req);
    wr(8'h2C, 8'h04);
    w16(8'h08, 16'hFFFF);
    ext(`TCC_CS_EXT_RISE, 1);
    rc("overflow", 8'h2C, 8'h01);
    r16("wrap", 8'h08, 16'h0000);
    wr(8'h2C, 8'h01);
    $display("compare done");
    // phase mode with compare a as top: 3 4 5 4 3
    // new top 4 waits for the turn at 5; channel a gets no pwm
    wr(8'h00, 8'hC6);
    w16(8'h08, 16'h0003);
    w16(8'h10, 16'h0004);
    ext(`TCC_CS_EXT_RISE, 4);
    r16("down count", 8'h08, 16'h0003);
    rc("top match", 8'h2C, 8'h02);
    chk("no pwm on a", 32'h1, wave_out_a);
    wr(8'h2C, 8'h02);
    // clear on top at 4: 3 4 0 1 2
    wr(8'h00, 8'h01);
    w16(8'h08, 16'h0003);
    ext(`TCC_CS_EXT_RISE, 4);
    r16("clear on top", 8'h08, 16'h0002);
    rc("ctc match", 8'h2C, 8'h02);
    wr(8'h2C, 8'h02);
    wr(8'h00, 8'h00);
    $display("phase done");
    w16(8'h08, 16'h1234);
    wr(8'h04, 8'h40);
    wr(8'h28, 8'h08);
    @(posedge aclk) capture_in_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    rc("capture flag", 8'h2C, 8'h08);
    chk("capture req", 32'h8, irq_req);
    r16("capture value", 8'h20, 16'h1234);
    @(posedge aclk) ack_en <= 4'h8;
    repeat (6) @(posedge aclk);
    rc("acked flag", 8'h2C, 8'h00);
    ack_en <= 4'h0;
    // three equal samples must not pass the filter
    wr(8'h04, 8'hC0);
    @(posedge aclk) capture_in_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    capture_in_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    capture_in_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    rc("glitch", 8'h2C, 8'h00);
    capture_in_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    rc("filtered", 8'h2C, 8'h08);
    wr(8'h04, 8'h60);
    wr(8'h2C, 8'h08);
    w16(8'h08, 16'h1256);
    @(posedge aclk) comparator_output <= 1'b1;
    repeat (8) @(posedge aclk);
    r16("comparator", 8'h20, 16'h1256);
    // counter runs every clock: only the high byte is fixed
    wr(8'h04, 8'h01);
    w16(8'h08, 16'h1000);
    rd(8'h08);
    rc("write wins", 8'h0C, 8'h10);
    wr(8'h04, 8'h00);
    $display("capture done");
    stop_test();
  end
endmodule // tb_tcc_timer16

// *** tcc_consts.vh ***
// constants for the 16-bit timer/counter core
// assumes a single 100 MHz clock and a 32-bit register bus
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TCC_OFS_CTRL_FIRST   8'h00
`define TCC_OFS_CTRL_SECOND  8'h04
`define TCC_OFS_CNT_LOW      8'h08
`define TCC_OFS_CNT_HIGH     8'h0C
`define TCC_OFS_CMPA_LOW     8'h10
`define TCC_OFS_CMPA_HIGH    8'h14
`define TCC_OFS_CMPB_LOW     8'h18
`define TCC_OFS_CMPB_HIGH    8'h1C
`define TCC_OFS_CAP_LOW      8'h20
`define TCC_OFS_CAP_HIGH     8'h24
`define TCC_OFS_MASK         8'h28
`define TCC_OFS_FLAG         8'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCC_F1_MODE_LSB      0
`define TCC_F1_COMB_LSB      4
`define TCC_F1_COMA_LSB      6
`define TCC_F2_CS_LSB        0
`define TCC_F2_CAPSRC_BIT    5
`define TCC_F2_EDGE_BIT      6
`define TCC_F2_FILT_BIT      7
`define TCC_FLG_OVF          0
`define TCC_FLG_MATCH_A      1
`define TCC_FLG_MATCH_B      2
`define TCC_FLG_CAPTURE      3

// ----------------------------------------------------------------
// reset values and fixed counts
// ----------------------------------------------------------------
`define TCC_RST_BYTE         8'h00
`define TCC_RST_WORD         16'h0000
`define TCC_MAX              16'hFFFF
`define TCC_FILT_DEPTH       4
`define TCC_RESP_OKAY        2'h0
`define TCC_RESP_SLVERR      2'h2

// ----------------------------------------------------------------
// counting modes (mode field)
// ----------------------------------------------------------------
`define TCC_M_NORMAL         3'h0
`define TCC_M_CTC_A          3'h1
`define TCC_M_CTC_CAP        3'h2
`define TCC_M_FAST_MAX       3'h3
`define TCC_M_FAST_A         3'h4
`define TCC_M_FAST_CAP       3'h5
`define TCC_M_PHASE_A        3'h6
`define TCC_M_PHASE_CAP      3'h7

// ----------------------------------------------------------------
// clock source select codes
// ----------------------------------------------------------------
`define TCC_CS_OFF           3'h0
`define TCC_CS_DIV1          3'h1
`define TCC_CS_DIV8          3'h2
`define TCC_CS_DIV64         3'h3
`define TCC_CS_DIV256        3'h4
`define TCC_CS_DIV1024       3'h5
`define TCC_CS_EXT_FALL      3'h6
`define TCC_CS_EXT_RISE      3'h7

`endif

// *** tcc_irq_host.sv ***
// processor-side model that executes timer interrupts
// assumes irq_req levels from the timer core on aclk

// ----------------------------------------------------------------
// interrupt acceptance
// ----------------------------------------------------------------
module tcc_irq_host (
  // clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  // request, per-source permission, acknowledge
  input  logic [3:0] irq_req,
  input  logic [3:0] ack_en,
  output logic [3:0] irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // handler runs only on a live request
  // never two pulses in a row: the flag needs one edge to clear
  always @(posedge aclk)
    if (!aresetn)
      irq_ack <= 4'h0;
    else
      irq_ack <= irq_req & ack_en & ~irq_ack;
endmodule // tcc_irq_host

// *** tcc_timer16.v ***
// 16-bit timer/counter with two compare channels and input capture
// assumes AXI4-Lite master on aclk and pins synchronous to aclk
//
// Summary of operation
// - counter, compares, capture are 16-bit
// - two 8-bit control registers, free access
// - every request visible in flag register
// - one mask bit per interrupt source
// - tick from prescaler or pin, edge selectable
// - no clock source selected: counter frozen
// - three-bit clock select in second control
// - double-buffered compares in PWM modes, compared on every counter tick
// - compare results drive waveform output pins
// - compare match sets channel match flag
// - capture counter on pin or comparator edge
// - optional noise filter on capture path
// - top from compare A, capture or fixed
// - compare A as top: no PWM on A
// - compare A top value double-buffered in PWM modes
// - four interrupt sources
// - two compare units, one capture unit
// - counter counts up or down by mode
// - shared high-byte shadow on low access
// - processor write beats clear or count
// - filter needs four equal samples
// - capture flag set; cleared by ack or one
`include "tcc_consts.vh"

module tcc_timer16 #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // axi4-lite write address and data
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output wire              awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output wire              wready,
  // axi4-lite write response
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  // axi4-lite read
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output wire              arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  // timer pins
  input  wire              external_count_pin,
  input  wire              capture_in_pin,
  input  wire              comparator_output,
  output reg               wave_out_a,
  output reg               wave_out_b,
  output reg               wave_en_a,
  output reg               wave_en_b,
  // interrupt requests and acknowledges
  output wire [3:0]        irq_req,
  input  wire [3:0]        irq_ack
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0]        ctrl_first_r;
  reg [7:0]        ctrl_second_r;
  reg [3:0]        timer_mask_r;
  reg [3:0]        timer_flag_r;
  reg [15:0]       count_value_r;
  reg              dir_up_r;
  reg [15:0]       cmp_a_buf_r;
  reg [15:0]       cmp_b_buf_r;
  reg [15:0]       cmp_a_act_r;
  reg [15:0]       cmp_b_act_r;
  reg [15:0]       capture_value_r;
  reg [7:0]        shadow_r;
  reg [9:0]        presc_r;
  reg              ext_prev_r;
  reg              cap_in_r;
  reg [3:0]        filt_pipe_r;
  reg              filt_r;
  reg              cap_prev_r;
  reg              aw_hold_r;
  reg              w_hold_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg [7:0]        w_byte_r;
  reg              w_lane_r;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one write and one read in flight; both halves held until joined
  assign awready = !aw_hold_r && !bvalid;
  assign wready  = !w_hold_r && !bvalid;
  assign arready = !rvalid;
  wire do_wr = aw_hold_r && w_hold_r && w_lane_r;
  wire wr_go = aw_hold_r && w_hold_r;
  wire do_rd = arvalid && arready;

  function wr_hit;
    input [ADDR_W-1:0] a;
    input [7:0]        ofs;
    begin
      wr_hit = (a == ofs[ADDR_W-1:0]);
    end
  endfunction

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire [2:0] mode     = ctrl_first_r[`TCC_F1_MODE_LSB +: 3];
  wire [1:0] com_a    = ctrl_first_r[`TCC_F1_COMA_LSB +: 2];
  wire [1:0] com_b    = ctrl_first_r[`TCC_F1_COMB_LSB +: 2];
  wire [2:0] cs       = ctrl_second_r[`TCC_F2_CS_LSB +: 3];
  wire top_is_a   = (mode == `TCC_M_CTC_A) || (mode == `TCC_M_FAST_A) ||
                    (mode == `TCC_M_PHASE_A);
  wire top_is_cap = (mode == `TCC_M_CTC_CAP) || (mode == `TCC_M_FAST_CAP)
                    || (mode == `TCC_M_PHASE_CAP);
  wire pwm_fast   = (mode == `TCC_M_FAST_MAX) || (mode == `TCC_M_FAST_A) ||
                    (mode == `TCC_M_FAST_CAP);
  wire pwm_phase  = (mode == `TCC_M_PHASE_A) || (mode == `TCC_M_PHASE_CAP);
  wire pwm_any    = pwm_fast || pwm_phase;

  reg [15:0] top_val;
  always @*
  begin
    if (top_is_a)
      top_val = cmp_a_act_r;
    else if (top_is_cap)
      top_val = capture_value_r;
    else
      top_val = `TCC_MAX;
  end
  wire at_top = (count_value_r == top_val);

  // ----------------------------------------------------------------
  // clock select
  // ----------------------------------------------------------------
  // prescaled or external edge tick
  reg timer_tick;
  always @*
  begin
    case (cs)
      `TCC_CS_DIV1:     timer_tick = 1'b1;
      `TCC_CS_DIV8:     timer_tick = &presc_r[2:0];
      `TCC_CS_DIV64:    timer_tick = &presc_r[5:0];
      `TCC_CS_DIV256:   timer_tick = &presc_r[7:0];
      `TCC_CS_DIV1024:  timer_tick = &presc_r[9:0];
      `TCC_CS_EXT_FALL: timer_tick = ext_prev_r && !external_count_pin;
      `TCC_CS_EXT_RISE: timer_tick = !ext_prev_r && external_count_pin;
      // no source: no tick at all
      default:          timer_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counter next value
  // ----------------------------------------------------------------
  // direction follows the counting mode
  reg [15:0] cnt_nxt;
  reg        dir_nxt;
  reg        ovf_evt;
  always @*
  begin
    cnt_nxt = count_value_r;
    dir_nxt = dir_up_r;
    ovf_evt = 1'b0;
    if (timer_tick)
    begin
      if (pwm_phase)
      begin
        if (dir_up_r && at_top)
        begin
          dir_nxt = 1'b0;
          cnt_nxt = count_value_r - 16'h0001;
        end
        else if (!dir_up_r && (count_value_r == 16'h0000))
        begin
          dir_nxt = 1'b1;
          cnt_nxt = count_value_r + 16'h0001;
        end
        else if (dir_up_r)
          cnt_nxt = count_value_r + 16'h0001;
        else
        begin
          cnt_nxt = count_value_r - 16'h0001;
          // overflow flagged on reaching bottom
          ovf_evt = (count_value_r == 16'h0001);
        end
      end
      else
      begin
        dir_nxt = 1'b1;
        if (mode != `TCC_M_NORMAL && at_top)
          cnt_nxt = 16'h0000;
        else
          cnt_nxt = count_value_r + 16'h0001;
        ovf_evt = pwm_fast ? at_top : (count_value_r == `TCC_MAX);
      end
    end
  end

  // match only on a counting tick
  wire match_a   = timer_tick && (count_value_r == cmp_a_act_r);
  wire match_b   = timer_tick && (count_value_r == cmp_b_act_r);
  wire bottom_ev = timer_tick && pwm_fast && at_top;

  // ----------------------------------------------------------------
  // capture input path
  // ----------------------------------------------------------------
  wire cap_src  = ctrl_second_r[`TCC_F2_CAPSRC_BIT] ? comparator_output
                                                   : capture_in_pin;
  wire cap_lvl  = ctrl_second_r[`TCC_F2_FILT_BIT] ? filt_r : cap_in_r;
  wire cap_edge = ctrl_second_r[`TCC_F2_EDGE_BIT] ? (cap_lvl && !cap_prev_r)
                                                 : (!cap_lvl && cap_prev_r);
  // capture register is the top: input path is switched off
  wire cap_evt  = cap_edge && !top_is_cap;

  // ----------------------------------------------------------------
  // waveform generator
  // ----------------------------------------------------------------
  // toggle/clear/set in plain modes, set-clear pairs in pwm modes
  function wave_fn;
    input       cur;
    input [1:0] com;
    input       mat;
    input       bot;
    input       up;
    input       fast;
    input       phase;
    input       no_pwm;
    begin
      wave_fn = cur;
      if ((fast || phase) && no_pwm)
      begin
        if (mat && com == 2'h1)
          wave_fn = !cur;
      end
      else if (fast)
      begin
        if (mat && com[1])
          wave_fn = com[0];
        else if (bot && com[1])
          wave_fn = !com[0];
      end
      else if (phase)
      begin
        if (mat && com[1])
          wave_fn = up ? com[0] : !com[0];
      end
      else if (mat)
      begin
        case (com)
          2'h1:    wave_fn = !cur;
          2'h2:    wave_fn = 1'b0;
          2'h3:    wave_fn = 1'b1;
          default: wave_fn = cur;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // sequential core
  // ----------------------------------------------------------------
  wire [7:0] wb       = w_byte_r;
  wire       wr_cnt   = do_wr && wr_hit(aw_addr_r, `TCC_OFS_CNT_LOW);
  wire       rd_cntlo = do_rd && wr_hit(araddr, `TCC_OFS_CNT_LOW);
  wire       rd_caplo = do_rd && wr_hit(araddr, `TCC_OFS_CAP_LOW);
  reg  [3:0] flag_set;
  reg  [3:0] flag_clr;
  always @*
  begin
    // four sources: overflow, match a, match b, capture
    flag_set = {cap_evt, match_b, match_a, ovf_evt};
    // cleared by ack or writing one
    flag_clr = irq_ack;
    if (do_wr && wr_hit(aw_addr_r, `TCC_OFS_FLAG))
      flag_clr = flag_clr | wb[3:0];
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_first_r    <= `TCC_RST_BYTE;
      ctrl_second_r   <= `TCC_RST_BYTE;
      timer_mask_r    <= 4'h0;
      timer_flag_r    <= 4'h0;
      count_value_r   <= `TCC_RST_WORD;
      dir_up_r        <= 1'b1;
      cmp_a_buf_r     <= `TCC_RST_WORD;
      cmp_b_buf_r     <= `TCC_RST_WORD;
      cmp_a_act_r     <= `TCC_RST_WORD;
      cmp_b_act_r     <= `TCC_RST_WORD;
      capture_value_r <= `TCC_RST_WORD;
      shadow_r        <= `TCC_RST_BYTE;
      presc_r         <= 10'h000;
      ext_prev_r      <= 1'b0;
      cap_in_r        <= 1'b0;
      filt_pipe_r     <= 4'h0;
      filt_r          <= 1'b0;
      cap_prev_r      <= 1'b0;
      wave_out_a      <= 1'b0;
      wave_out_b      <= 1'b0;
      wave_en_a       <= 1'b0;
      wave_en_b       <= 1'b0;
    end
    else
    begin
      presc_r    <= presc_r + 10'h001;
      ext_prev_r <= external_count_pin;
      // filter output moves on four equal samples
      cap_in_r    <= cap_src;
      filt_pipe_r <= {filt_pipe_r[2:0], cap_in_r};
      if (&filt_pipe_r || ~|filt_pipe_r)
        filt_r <= filt_pipe_r[3];
      cap_prev_r <= cap_lvl;

      if (wr_cnt)
        count_value_r <= {shadow_r, wb};
      else
        count_value_r <= cnt_nxt;
      dir_up_r <= dir_nxt;

      // compare a top buffered until update point
      if (!pwm_any || bottom_ev ||
          (pwm_phase && timer_tick && dir_up_r && at_top))
      begin
        cmp_a_act_r <= cmp_a_buf_r;
        cmp_b_act_r <= cmp_b_buf_r;
      end

      if (cap_evt)
        capture_value_r <= count_value_r;
      else if (do_wr && top_is_cap && wr_hit(aw_addr_r, `TCC_OFS_CAP_LOW))
        capture_value_r <= {shadow_r, wb};

      // set wins over a same-cycle clear
      timer_flag_r <= (timer_flag_r & ~flag_clr) | flag_set;

      // no pwm on channel a when it is top
      wave_out_a <= wave_fn(wave_out_a, com_a, match_a, bottom_ev,
                            dir_up_r, pwm_fast, pwm_phase, top_is_a);
      wave_out_b <= wave_fn(wave_out_b, com_b, match_b, bottom_ev,
                            dir_up_r, pwm_fast, pwm_phase, 1'b0);
      wave_en_a  <= (com_a != 2'h0);
      wave_en_b  <= (com_b != 2'h0);

      if (rd_cntlo)
        shadow_r <= count_value_r[15:8];
      else if (rd_caplo)
        shadow_r <= capture_value_r[15:8];

      if (do_wr)
      begin
        case (aw_addr_r)
          `TCC_OFS_CTRL_FIRST:  ctrl_first_r  <= wb;
          `TCC_OFS_CTRL_SECOND: ctrl_second_r <= wb;
          `TCC_OFS_MASK:        timer_mask_r  <= wb[3:0];
          `TCC_OFS_CMPA_LOW:    cmp_a_buf_r   <= {shadow_r, wb};
          `TCC_OFS_CMPB_LOW:    cmp_b_buf_r   <= {shadow_r, wb};
          `TCC_OFS_CNT_HIGH,
          `TCC_OFS_CMPA_HIGH,
          `TCC_OFS_CMPB_HIGH,
          `TCC_OFS_CAP_HIGH:    shadow_r      <= wb;
          // keeps a same-cycle low-byte read load of the shadow
          default:              ;
        endcase
      end
    end
  end

  // request gated by flag and mask
  assign irq_req = timer_flag_r & timer_mask_r;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  // address and data may arrive in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_byte_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `TCC_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold_r <= 1'b1;
        w_byte_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
      end
      if (wr_go)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (aw_addr_r[1:0] == 2'h0 &&
                      aw_addr_r <= `TCC_OFS_FLAG) ? `TCC_RESP_OKAY
                                                  : `TCC_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  // flag register shows every request source
  // 16-bit values read as two bytes
  reg [7:0] rd_byte;
  reg       rd_ok;
  always @*
  begin
    rd_ok = 1'b1;
    case (araddr)
      `TCC_OFS_CTRL_FIRST:  rd_byte = ctrl_first_r;
      `TCC_OFS_CTRL_SECOND: rd_byte = ctrl_second_r;
      `TCC_OFS_CNT_LOW:     rd_byte = count_value_r[7:0];
      `TCC_OFS_CNT_HIGH:    rd_byte = shadow_r;
      `TCC_OFS_CMPA_LOW:    rd_byte = cmp_a_buf_r[7:0];
      `TCC_OFS_CMPA_HIGH:   rd_byte = cmp_a_buf_r[15:8];
      `TCC_OFS_CMPB_LOW:    rd_byte = cmp_b_buf_r[7:0];
      `TCC_OFS_CMPB_HIGH:   rd_byte = cmp_b_buf_r[15:8];
      `TCC_OFS_CAP_LOW:     rd_byte = capture_value_r[7:0];
      `TCC_OFS_CAP_HIGH:    rd_byte = shadow_r;
      `TCC_OFS_MASK:        rd_byte = {4'h0, timer_mask_r};
      `TCC_OFS_FLAG:        rd_byte = {4'h0, timer_flag_r};
      default:
      begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `TCC_RESP_OKAY;
    end
    else if (do_rd)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_byte};
      rresp  <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

endmodule // tcc_timer16

// *** tcc_timer16_asserts.sv ***
// bus and interrupt port checks for the 16-bit timer core
// assumes one clock domain and a synchronous active-low reset
`include "tcc_consts.vh"

// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module tcc_timer16_chk (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // write channels
  input logic        awvalid,
  input logic        awready,
  input logic        wvalid,
  input logic        wready,
  input logic [1:0]  bresp,
  input logic        bvalid,
  input logic        bready,
  // read channels
  input logic        arvalid,
  input logic        arready,
  input logic [31:0] rdata,
  input logic [1:0]  rresp,
  input logic        rvalid,
  input logic        rready,
  // interrupt lines
  input logic [3:0]  irq_req,
  input logic [3:0]  irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // single domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_lat; awvalid && awready && wvalid && wready |=> ##1 bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  property p_b_done; bvalid && bready |=> !bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid stuck");
  property p_w_block; bvalid |-> !awready && !wready; endproperty
  a_w_block: assert property (p_w_block) else $error("write overrun");
  property p_r_lat; arvalid && arready |=> rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  property p_r_block; rvalid |-> !arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read overrun");
  // registers are one byte wide, refused reads give zero
  property p_r_data; rvalid |-> rdata[31:8] == 24'h0 &&
    (rresp != `TCC_RESP_SLVERR || rdata == 32'h0); endproperty
  a_r_data: assert property (p_r_data) else $error("read data wide");
  property p_ack; irq_ack[3] |=> !irq_req[3]; endproperty
  a_ack: assert property (p_ack) else $error("capture ack ignored");
endmodule // tcc_timer16_chk

bind tcc_timer16 tcc_timer16_chk i_tcc_timer16_chk (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .irq_req, .irq_ack);
